// ### src/reset_cause_consts.svh
// constants for the reset cause and debug force reset block
`ifndef RESET_CAUSE_CONSTS_SVH
`define RESET_CAUSE_CONSTS_SVH
`define RC_ADDR_STATUS 8'h00
`define RC_ADDR_FORCE 8'h01
`define RC_BIT_POWER_ON 7
`define RC_BIT_PIN 6
`define RC_BIT_WATCHDOG 5
`define RC_BIT_BAD_OPCODE 4
`define RC_BIT_BAD_ADDRESS 3
`define RC_BIT_LOW_VOLTAGE 1
`define RC_BIT_FORCE 0
`define RC_STATUS_RESET 8'h82
`define RC_FORCE_READ 8'h00
`define RC_RESET_HOLD_CYCLES 4'h8
`endif

// ### src/reset_cause_pkg.sv
// types for the reset cause and debug force reset block
package reset_cause_pkg;
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_address;
    logic low_voltage;
    logic force_reset;
  } reset_sources_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01
  } seq_state_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] rdata;
    logic watchdog_restart;
    logic system_reset;
    logic [3:0] hold_cnt;
    seq_state_t state;
  } core_state_t;
endpackage

// ### src/reset_source_gate.sv
// qualifies raw reset requests into cause bits
`timescale 1ns/10ps
`default_nettype none
module reset_source_gate (
  input wire logic pin_reset_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic bad_opcode_i,
  input wire logic stop_instr_i,
  input wire logic stop_mode_enable_i,
  input wire logic enter_background_instr_instr_i,
  input wire logic background_mode_enable_i,
  input wire logic bad_address_i,
  input wire logic low_supply_i,
  input wire logic stop_mode_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic low_voltage_stop_enable_i,
  output reset_cause_pkg::reset_sources_t src_o
);
  always_comb begin
    src_o = '0;
    src_o.pin = ~pin_reset_n_i;
    src_o.watchdog = watchdog_timeout_i & watchdog_enable_i;
    src_o.bad_opcode = bad_opcode_i | (stop_instr_i & ~stop_mode_enable_i)
                     | (enter_background_instr_instr_i & ~background_mode_enable_i);
    src_o.bad_address = bad_address_i;
    src_o.low_voltage = low_supply_i & low_voltage_reset_enable_i
                      & (~stop_mode_i | low_voltage_stop_enable_i);
  end
endmodule
`default_nettype wire

// ### src/reset_cause_status.sv
// reset cause status register, watchdog restart and debug forced reset
`timescale 1ns/10ps
`default_nettype none
`include "reset_cause_consts.svh"
module reset_cause_status (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic power_on_i,
  input wire logic pin_reset_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic bad_opcode_i,
  input wire logic stop_instr_i,
  input wire logic stop_mode_enable_i,
  input wire logic enter_background_instr_instr_i,
  input wire logic background_mode_enable_i,
  input wire logic bad_address_i,
  input wire logic low_supply_i,
  input wire logic stop_mode_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic low_voltage_stop_enable_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bdm_access_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic watchdog_restart_o,
  output logic system_reset_o
);
  ////////////////////////////////////////////////////////////////
  reset_cause_pkg::reset_sources_t src;
  reset_cause_pkg::core_state_t st_r;
  reset_cause_pkg::core_state_t st_nxt;
  logic force_req;
  logic any_req;

  function automatic logic hits_status(input logic [7:0] a);
    return a == `RC_ADDR_STATUS;
  endfunction

  function automatic logic hits_force(input logic [7:0] a);
    return a == `RC_ADDR_FORCE;
  endfunction

  reset_source_gate u_gate (
    .pin_reset_n_i(pin_reset_n_i),
    .watchdog_timeout_i(watchdog_timeout_i),
    .watchdog_enable_i(watchdog_enable_i),
    .bad_opcode_i(bad_opcode_i),
    .stop_instr_i(stop_instr_i),
    .stop_mode_enable_i(stop_mode_enable_i),
    .enter_background_instr_instr_i(enter_background_instr_instr_i),
    .background_mode_enable_i(background_mode_enable_i),
    .bad_address_i(bad_address_i),
    .low_supply_i(low_supply_i),
    .stop_mode_i(stop_mode_i),
    .low_voltage_reset_enable_i(low_voltage_reset_enable_i),
    .low_voltage_stop_enable_i(low_voltage_stop_enable_i),
    .src_o(src)
  );

  // user program writes never reach the force bit
  assign force_req = wr_i & bdm_access_i & hits_force(addr_i)
                   & wdata_i[`RC_BIT_FORCE];

  assign any_req = src.pin | src.watchdog | src.bad_opcode | src.bad_address
                 | src.low_voltage | force_req;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.watchdog_restart = wr_i & hits_status(addr_i);
    st_nxt.rdata = 8'h00;
    if (rd_i && hits_status(addr_i)) begin
      st_nxt.rdata = st_r.status;
    end else if (rd_i && hits_force(addr_i)) begin
      st_nxt.rdata = `RC_FORCE_READ;
    end
    unique case (st_r.state)
      reset_cause_pkg::ST_RUN: begin
        st_nxt.system_reset = 1'b0;
        if (any_req) begin
          st_nxt.state = reset_cause_pkg::ST_HOLD;
          st_nxt.system_reset = 1'b1;
          st_nxt.hold_cnt = `RC_RESET_HOLD_CYCLES;
          st_nxt.watchdog_restart = 1'b1;
          st_nxt.status = 8'h00;
          if (src.low_voltage) begin
            // power-on flag survives a low-voltage reset
            st_nxt.status[`RC_BIT_POWER_ON] = st_r.status[`RC_BIT_POWER_ON];
            st_nxt.status[`RC_BIT_LOW_VOLTAGE] = 1'b1;
          end else if (!force_req) begin
            st_nxt.status[`RC_BIT_PIN] = src.pin;
            st_nxt.status[`RC_BIT_WATCHDOG] = src.watchdog;
            st_nxt.status[`RC_BIT_BAD_OPCODE] = src.bad_opcode;
            st_nxt.status[`RC_BIT_BAD_ADDRESS] = src.bad_address;
          end
        end
      end
      reset_cause_pkg::ST_HOLD: begin
        st_nxt.system_reset = 1'b1;
        st_nxt.hold_cnt = st_r.hold_cnt - 4'h1;
        if (st_r.hold_cnt == 4'h1) begin
          st_nxt.state = reset_cause_pkg::ST_RUN;
          st_nxt.system_reset = 1'b0;
        end
      end
      default: begin
        st_nxt.state = reset_cause_pkg::ST_RUN;
      end
    endcase
  end

  // reset_i or power_on_i loads the power-on status; either must be held while supply ramps
  always_ff @(posedge mclk_i) begin
    if (reset_i || power_on_i) begin
      st_r <= '0;
      st_r.status <= `RC_STATUS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign watchdog_restart_o = st_r.watchdog_restart;
  assign system_reset_o = st_r.system_reset;
endmodule
`default_nettype wire

// ### verification/reset_source_model.sv
// reset sources that stand idle until fired for one cycle
`timescale 1ns/10ps
`default_nettype none
module reset_source_model (
  input wire logic mclk_i,
  output logic [12:0] src_o
);
  // pin high by pull-up, enables set except low-voltage in stop, no fault raised
  localparam logic [12:0] IDLE = 13'h14a2;
  initial src_o = IDLE;
  task automatic fire(input logic [12:0] v);
    @(negedge mclk_i) src_o = v;
    @(negedge mclk_i) src_o = IDLE;
  endtask
endmodule
`default_nettype wire

// ### verification/reset_cause_properties.sv
// concurrent checks on the reset cause status ports
`timescale 1ns/10ps
`default_nettype none
module reset_cause_properties (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic power_on_i,
  input wire logic pin_reset_n_i,
  input wire logic bad_opcode_i,
  input wire logic bad_address_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bdm_access_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic watchdog_restart_o,
  input wire logic system_reset_o
);
  default clocking @(posedge mclk_i); endclocking
  // power-on clears the state just like reset, so both silence the checks
  default disable iff (reset_i || power_on_i);
  a_force_reads_zero: assert property (rd_i && addr_i == 8'h01 |=> rdata_o == 8'h00)
    else $error("force read");
  a_unused_bits_zero: assert property (rd_i |=> rdata_o[2] == 1'b0 && rdata_o[0] == 1'b0)
    else $error("unused bits");
  a_write_restarts: assert property (wr_i && addr_i == 8'h00 |=> watchdog_restart_o)
    else $error("no restart");
  a_debug_forces: assert property
    (wr_i && addr_i == 8'h01 && bdm_access_i && wdata_i[0] && !system_reset_o |=> system_reset_o)
    else $error("no force");
  a_hold_eight: assert property ($rose(system_reset_o) |-> system_reset_o[*8] ##1 !system_reset_o)
    else $error("hold length");
  a_pin_resets: assert property (!pin_reset_n_i && !system_reset_o |=> system_reset_o)
    else $error("pin");
  a_opcode_resets: assert property (bad_opcode_i && !system_reset_o |=> system_reset_o)
    else $error("opcode");
  a_address_resets: assert property (bad_address_i && !system_reset_o |=> system_reset_o)
    else $error("address");
endmodule
bind reset_cause_status reset_cause_properties checker_i (.*);
`default_nettype wire

// ### verification/reset_cause_status_test.sv
// self-checking bench for the reset cause status block
`timescale 1ns/10ps
`default_nettype none
module reset_cause_status_test;
  logic mclk_i = 1'b0, reset_i = 1'b1, power_on_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, bdm_access_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [12:0] src_o;
  logic watchdog_restart_o, system_reset_o;
  int n_fail = 0, tests_run = 0, cycles = 0;
  reset_source_model P (.*);
  reset_cause_status DUT (.pin_reset_n_i(src_o[12]), .watchdog_timeout_i(src_o[11]), .watchdog_enable_i(src_o[10]),
    .bad_opcode_i(src_o[9]), .stop_instr_i(src_o[8]), .stop_mode_enable_i(src_o[7]), .enter_background_instr_instr_i(src_o[6]),
    .background_mode_enable_i(src_o[5]), .bad_address_i(src_o[4]), .low_supply_i(src_o[3]), .stop_mode_i(src_o[2]),
    .low_voltage_reset_enable_i(src_o[1]), .low_voltage_stop_enable_i(src_o[0]), .*);
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // released bus lines show the inverse so stale values never pass for answers
  task automatic access(input logic w, b, input logic [7:0] a, d);
    @(negedge mclk_i);
    {wr_i, rd_i, bdm_access_i, addr_i, wdata_i} = {w, !w, b, a, d};
    @(negedge mclk_i);
    {wr_i, rd_i, bdm_access_i, addr_i, wdata_i} = {3'b000, ~a, ~d};
  endtask
  task automatic status_is(input logic [7:0] exp);
    access(1'b0, 1'b0, 8'h00, 8'h00);
    check("status", exp, rdata_o);
  endtask
  task automatic cause(input logic [12:0] v, input logic r, input logic [7:0] exp);
    P.fire(v);
    check("reset out", {7'h00, r}, {7'h00, system_reset_o});
    repeat (10) @(negedge mclk_i);
    status_is(exp);
  endtask
  task automatic t_causes;
    status_is(8'h82);
    cause(13'h14aa, 1'b1, 8'h82);
    cause(13'h04a2, 1'b1, 8'h40);
    cause(13'h14aa, 1'b1, 8'h02);
    cause(13'h1522, 1'b1, 8'h10);
    cause(13'h16a2, 1'b1, 8'h10);
    cause(13'h1ca2, 1'b1, 8'h20);
    cause(13'h14c2, 1'b1, 8'h10);
    cause(13'h14b2, 1'b1, 8'h08);
    cause(13'h14af, 1'b1, 8'h02);
    cause(13'h0ca2, 1'b1, 8'h60);
    cause(13'h18a2, 1'b0, 8'h60);
    cause(13'h14ae, 1'b0, 8'h60);
  endtask
  task automatic t_regs;
    access(1'b0, 1'b0, 8'h01, 8'h00);
    check("force read", 8'h00, rdata_o);
    access(1'b1, 1'b0, 8'h00, 8'h55);
    check("restart", 8'h01, {7'h00, watchdog_restart_o});
    status_is(8'h60);
    access(1'b1, 1'b0, 8'h01, 8'h01);
    check("user force", 8'h00, {7'h00, system_reset_o});
    access(1'b1, 1'b1, 8'h01, 8'h01);
    check("debug force", 8'h01, {7'h00, system_reset_o});
    repeat (10) @(negedge mclk_i);
    status_is(8'h00);
  endtask
  task automatic t_power_on;
    @(negedge mclk_i) power_on_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    power_on_i = 1'b0;
    check("power-on reset out", 8'h00, {7'h00, system_reset_o});
    status_is(8'h82);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    reset_i = 1'b0;
    t_causes();
    t_regs();
    t_power_on();
    conclude();
  end
endmodule
`default_nettype wire
